// *** rtl/cmr_clock_mode_reset.sv ***
// clock mode selection, reset sequencer and watchdog
`timescale 1ns/1ps
`default_nettype none
module cmr_clock_mode_reset (
   input  wire logic       clk,
   input  wire logic       rst,
   // pll configuration from software
   input  wire logic       pllCfgWr,
   input  wire logic [5:0] pllCfgSynDiv,
   input  wire logic [4:0] pllCfgPostDiv,
   input  wire logic       oscEnWr,
   input  wire logic       oscEnData,
   input  wire logic       pllSelWr,
   input  wire logic       pllSelData,
   input  wire logic       lockFlagClr,
   input  wire logic       oscFlagClr,
   // analog status
   input  wire logic       pllLock,
   input  wire logic       oscFilterOk,
   input  wire logic       oscFilterPause,
   input  wire logic       oscFail,
   // power modes
   input  wire logic       stopMode,
   input  wire logic       fullStopMode,
   input  wire logic       pseudoStopEn,
   input  wire logic       normalMode,
   // watchdog control
   input  wire logic       wdCfgWr,
   input  wire logic       wdCfgWindowEn,
   input  wire logic [2:0] wdCfgRate,
   input  wire logic       wdCfgClkSel,
   input  wire logic       wdCfgPseudoStopEn,
   input  wire logic       wdSvcWr,
   input  wire logic [7:0] wdSvcData,
   input  wire logic       ircTick,
   input  wire logic       xtalTick,
   // reset sources and pin
   input  wire logic       lowSupplyReset,
   input  wire logic       illegalAddrReset,
   input  wire logic       resetPinIn,
   // outputs
   output var  logic [5:0] synDiv_reg,
   output var  logic [4:0] postDivEff_reg,
   output var  logic       pllRefFromXtal_reg,
   output var  logic       oscEnableEff_reg,
   output var  logic       busClkFromPll_reg,
   output var  logic       busClkPause_reg,
   output var  logic       vcoResetFreq_reg,
   output var  logic       oscQualified_reg,
   output var  logic       lockChangeFlag_reg,
   output var  logic       oscChangeFlag_reg,
   output var  logic       wdClkFromXtal_reg,
   output var  logic       wdCfgLocked_reg,
   output var  logic [2:0] wdRate_reg,
   output var  logic       wdWindowEn_reg,
   output var  logic       resetPinOut_reg,
   output var  logic       resetPinOe_reg,
   output var  logic       internalReset_reg,
   output var  logic [1:0] resetVector_reg,
   output var  logic       resetVectorValid_reg
);
   // ----------------------------------------------------------------------
   // internal state
   // ----------------------------------------------------------------------
   cmr_pkg::cmr_rst_state_e rstState_reg;
   logic [cmr_pkg::RST_CNT_W-1:0] rstCnt_reg;
   logic [4:0] output_divider_field_reg;
   logic       oscEn_reg;
   logic       lockPrev_reg;
   logic       wdClkSel_reg;
   logic       wdPseudoStop_reg;
   logic       wdArmed_reg;
   logic       cmPending_reg;
   logic       wdPending_reg;
   logic       pinLowIdle_reg;
   logic       cfgClear;
   logic       oscQualNext;
   logic       wdEnabled;
   logic       wdUseXtal;
   logic       wdRun;
   logic       wdTick;
   logic       wdRestart;
   logic       wdBadWrite;
   logic       wdExpired;
   logic       wdInWindow;
   logic       cmFailNow;
   logic       anySource;

   // configuration returns to defaults during the whole system reset
   assign cfgClear = rst || internalReset_reg;

   // ----------------------------------------------------------------------
   // pll configuration
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (cfgClear) begin
         synDiv_reg  <= cmr_pkg::SYN_DIV_RESET;
         output_divider_field_reg <= cmr_pkg::POST_DIV_RESET;
      end else if (pllCfgWr) begin
         synDiv_reg  <= pllCfgSynDiv;
         output_divider_field_reg <= pllCfgPostDiv;
      end
   end

   // programmed divider only once locked
   always_ff @(posedge clk) begin
      if (cfgClear) begin
         postDivEff_reg <= cmr_pkg::POST_DIV_UNLOCKED;
      end else begin
         postDivEff_reg <= pllLock ? output_divider_field_reg : cmr_pkg::POST_DIV_UNLOCKED;
      end
   end

   // reset frequency for the vco while the system reset stands
   always_ff @(posedge clk) begin
      if (rst) begin
         vcoResetFreq_reg <= 1'b1;
      end else begin
         vcoResetFreq_reg <= (rstState_reg != cmr_pkg::RS_IDLE) || !resetPinIn;
      end
   end

   // ----------------------------------------------------------------------
   // oscillator enable and reference selection
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (cfgClear) begin
         oscEn_reg <= cmr_pkg::OSC_EN_RESET;
      end else if (oscEnWr) begin
         oscEn_reg <= oscEnData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         oscEnableEff_reg   <= cmr_pkg::OSC_EN_RESET;
         pllRefFromXtal_reg <= cmr_pkg::OSC_EN_RESET;
      end else begin
         oscEnableEff_reg   <= oscEn_reg && !fullStopMode;
         pllRefFromXtal_reg <= oscEn_reg;
      end
   end

   // ----------------------------------------------------------------------
   // qualification status and change flags
   // ----------------------------------------------------------------------
   assign oscQualNext = oscEnableEff_reg && oscFilterOk && pllLock;

   always_ff @(posedge clk) begin
      if (rst) begin
         oscQualified_reg <= 1'b0;
         lockPrev_reg     <= 1'b0;
      end else begin
         oscQualified_reg <= oscQualNext;
         lockPrev_reg     <= pllLock;
      end
   end

   // a transition in the clearing cycle keeps the flag set
   always_ff @(posedge clk) begin
      if (cfgClear) begin
         lockChangeFlag_reg <= 1'b0;
      end else if (pllLock != lockPrev_reg) begin
         lockChangeFlag_reg <= 1'b1;
      end else if (lockFlagClr) begin
         lockChangeFlag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (cfgClear) begin
         oscChangeFlag_reg <= 1'b0;
      end else if (oscQualNext != oscQualified_reg) begin
         oscChangeFlag_reg <= 1'b1;
      end else if (oscFlagClr) begin
         oscChangeFlag_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // bus clock source
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (cfgClear) begin
         busClkFromPll_reg <= cmr_pkg::PLL_SEL_RESET;
      end else if (!busClkFromPll_reg && oscQualified_reg && !oscQualNext) begin
         busClkFromPll_reg <= 1'b1;
      end else if (pllSelWr) begin
         busClkFromPll_reg <= pllSelData;
      end
   end

   // filtered xtal may stall the bus clock in bypass mode
   always_ff @(posedge clk) begin
      if (cfgClear) begin
         busClkPause_reg <= 1'b0;
      end else begin
         busClkPause_reg <= !busClkFromPll_reg && oscFilterPause;
      end
   end

   // ----------------------------------------------------------------------
   // watchdog configuration, rate and window locked by the first write in normal mode
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (cfgClear) begin
         wdRate_reg       <= cmr_pkg::WD_RATE_OFF;
         wdWindowEn_reg   <= 1'b0;
         wdClkSel_reg     <= 1'b0;
         wdPseudoStop_reg <= 1'b0;
         wdCfgLocked_reg  <= 1'b0;
      end else if (wdCfgWr) begin
         wdClkSel_reg     <= wdCfgClkSel;
         wdPseudoStop_reg <= wdCfgPseudoStopEn;
         if (!wdCfgLocked_reg) begin
            wdRate_reg     <= wdCfgRate;
            wdWindowEn_reg <= wdCfgWindowEn;
         end
         if (normalMode) begin
            wdCfgLocked_reg <= 1'b1;
         end
      end
   end

   // internal reference unless the xtal is running and selected
   assign wdUseXtal = wdClkSel_reg && oscEnableEff_reg;
   assign wdRun     = !stopMode || (pseudoStopEn && wdClkSel_reg && wdPseudoStop_reg);
   assign wdTick    = wdRun && (wdUseXtal ? xtalTick : ircTick);
   assign wdEnabled = wdRate_reg != cmr_pkg::WD_RATE_OFF;

   always_ff @(posedge clk) begin
      if (rst) begin
         wdClkFromXtal_reg <= 1'b0;
      end else begin
         wdClkFromXtal_reg <= wdUseXtal;
      end
   end

   // ----------------------------------------------------------------------
   // watchdog service sequence
   // ----------------------------------------------------------------------
   always_comb begin
      wdRestart  = 1'b0;
      wdBadWrite = 1'b0;
      if (wdEnabled && wdSvcWr) begin
         if (wdWindowEn_reg && !wdInWindow) begin
            wdBadWrite = 1'b1;
         end else if (wdSvcData == cmr_pkg::WD_CODE_SERVE) begin
            wdRestart = wdArmed_reg;
         end else if (wdSvcData != cmr_pkg::WD_CODE_ARM) begin
            wdBadWrite = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (cfgClear) begin
         wdArmed_reg <= 1'b0;
      end else if (wdEnabled && wdSvcWr) begin
         wdArmed_reg <= (wdSvcData == cmr_pkg::WD_CODE_ARM) && !wdBadWrite;
      end
   end

   cmr_wd_counter wdCounter (
      .clk          (clk),
      .clear        (cfgClear || wdRestart),
      .tickEn       (wdTick),
      .rate         (wdRate_reg),
      .expired_reg  (wdExpired),
      .inWindow_reg (wdInWindow)
   );

   // ----------------------------------------------------------------------
   // reset causes
   // ----------------------------------------------------------------------
   assign cmFailNow = oscEnableEff_reg && oscFail;
   assign anySource = lowSupplyReset || illegalAddrReset || cmFailNow
                      || wdExpired || wdBadWrite || pinLowIdle_reg;

   // an idle low pin is an external reset request
   always_ff @(posedge clk) begin
      if (rst) begin
         pinLowIdle_reg <= 1'b0;
      end else begin
         pinLowIdle_reg <= !resetPinIn && rstState_reg == cmr_pkg::RS_IDLE;
      end
   end

   // pending causes held until the vector is chosen
   always_ff @(posedge clk) begin
      if (rst || resetVectorValid_reg) begin
         cmPending_reg <= 1'b0;
         wdPending_reg <= 1'b0;
      end else begin
         if (cmFailNow) begin
            cmPending_reg <= 1'b1;
         end
         if (wdExpired || wdBadWrite) begin
            wdPending_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // reset sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         rstState_reg <= cmr_pkg::RS_DRIVE;
         rstCnt_reg   <= '0;
      end else begin
         case (rstState_reg)
            cmr_pkg::RS_IDLE: begin
               rstCnt_reg <= '0;
               if (anySource) begin
                  rstState_reg <= cmr_pkg::RS_DRIVE;
               end
            end
            cmr_pkg::RS_DRIVE: begin
               if (rstCnt_reg == cmr_pkg::RST_DRIVE_LAST) begin
                  rstCnt_reg   <= '0;
                  rstState_reg <= cmr_pkg::RS_RELEASE;
               end else begin
                  rstCnt_reg <= rstCnt_reg + 1'b1;
               end
            end
            cmr_pkg::RS_RELEASE: begin
               if (rstCnt_reg == cmr_pkg::RST_RELEASE_LAST) begin
                  rstCnt_reg   <= '0;
                  rstState_reg <= resetPinIn ? cmr_pkg::RS_IDLE : cmr_pkg::RS_EXTEND;
               end else begin
                  rstCnt_reg <= rstCnt_reg + 1'b1;
               end
            end
            cmr_pkg::RS_EXTEND: begin
               rstCnt_reg <= '0;
               if (resetPinIn) begin
                  rstState_reg <= cmr_pkg::RS_IDLE;
               end
            end
            default: begin
               rstCnt_reg   <= '0;
               rstState_reg <= cmr_pkg::RS_DRIVE;
            end
         endcase
      end
   end

   // pin driven low only in the drive phase
   always_ff @(posedge clk) begin
      if (rst) begin
         resetPinOut_reg <= 1'b0;
         resetPinOe_reg  <= 1'b1;
      end else begin
         resetPinOut_reg <= 1'b0;
         resetPinOe_reg  <= (rstState_reg == cmr_pkg::RS_DRIVE
                             && rstCnt_reg != cmr_pkg::RST_DRIVE_LAST)
                            || (rstState_reg == cmr_pkg::RS_IDLE && anySource);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         internalReset_reg <= 1'b1;
      end else begin
         internalReset_reg <= !(rstState_reg == cmr_pkg::RS_IDLE && !anySource)
                              && !(rstState_reg == cmr_pkg::RS_RELEASE
                                   && rstCnt_reg == cmr_pkg::RST_RELEASE_LAST && resetPinIn)
                              && !(rstState_reg == cmr_pkg::RS_EXTEND && resetPinIn);
      end
   end

   // vector decision at the sampling point
   always_ff @(posedge clk) begin
      if (rst) begin
         resetVector_reg      <= cmr_pkg::VEC_POWER_ON_EXT;
         resetVectorValid_reg <= 1'b0;
      end else if (rstState_reg == cmr_pkg::RS_RELEASE
                   && rstCnt_reg == cmr_pkg::RST_RELEASE_LAST) begin
         resetVectorValid_reg <= 1'b1;
         if (!resetPinIn) begin
            resetVector_reg <= cmr_pkg::VEC_POWER_ON_EXT;
         end else if (cmPending_reg) begin
            resetVector_reg <= cmr_pkg::VEC_CLOCK_MON;
         end else if (wdPending_reg) begin
            resetVector_reg <= cmr_pkg::VEC_WATCHDOG;
         end else begin
            resetVector_reg <= cmr_pkg::VEC_POWER_ON_EXT;
         end
      end else begin
         resetVectorValid_reg <= 1'b0;
      end
   end
endmodule : cmr_clock_mode_reset
`default_nettype wire

// *** include/cmr_pkg.sv ***
// package of constants and types for the clock mode, reset and watchdog block
`default_nettype none
package cmr_pkg;
   // ----------------------------------------------------------------------
   // pll defaults after reset
   // ----------------------------------------------------------------------
   localparam logic [5:0] SYN_DIV_RESET  = 6'h1F;    // 1 MHz ref to 64 MHz vco
   localparam logic [4:0] POST_DIV_RESET = 5'h03;    // 64 MHz vco to 16 MHz pll
   localparam logic [4:0] POST_DIV_UNLOCKED = 5'h03; // vco divided by four
   localparam logic       PLL_SEL_RESET  = 1'b1;
   localparam logic       OSC_EN_RESET   = 1'b0;

   // ----------------------------------------------------------------------
   // reset sequence lengths in pll clock cycles
   // ----------------------------------------------------------------------
   localparam int unsigned RST_DRIVE_CYCLES   = 512;
   localparam int unsigned RST_RELEASE_CYCLES = 256;
   localparam int unsigned RST_TOTAL_CYCLES   = RST_DRIVE_CYCLES + RST_RELEASE_CYCLES;
   localparam int unsigned RST_CNT_W          = 10;
   localparam logic [RST_CNT_W-1:0] RST_DRIVE_LAST   = 10'h1FF;
   localparam logic [RST_CNT_W-1:0] RST_RELEASE_LAST = 10'h0FF;

   // ----------------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------------
   localparam logic [7:0] WD_CODE_ARM   = 8'h55;
   localparam logic [7:0] WD_CODE_SERVE = 8'hAA;
   localparam logic [2:0] WD_RATE_OFF   = 3'h0;
   localparam int unsigned WD_CNT_W     = 25;
   localparam int unsigned WD_EXP_BASE  = 10;   // period = 2^(base + 2*rate) ticks
   localparam int unsigned WD_EXP_STEP  = 2;

   // ----------------------------------------------------------------------
   // reset vectors and sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      VEC_POWER_ON_EXT = 2'b00,
      VEC_CLOCK_MON    = 2'b01,
      VEC_WATCHDOG     = 2'b10
   } cmr_vector_e;

   typedef enum logic [1:0] {
      RS_IDLE    = 2'b00,
      RS_DRIVE   = 2'b01,
      RS_RELEASE = 2'b10,
      RS_EXTEND  = 2'b11
   } cmr_rst_state_e;
endpackage : cmr_pkg
`default_nettype wire

// *** rtl/cmr_wd_counter.sv ***
// watchdog timeout counter with window flag
`timescale 1ns/1ps
`default_nettype none
module cmr_wd_counter (
   input  wire logic       clk,
   input  wire logic       clear,
   input  wire logic       tickEn,
   input  wire logic [2:0] rate,
   output var  logic       expired_reg,
   output var  logic       inWindow_reg
);
   logic [cmr_pkg::WD_CNT_W-1:0] count_reg;
   logic [cmr_pkg::WD_CNT_W-1:0] limit;
   logic [cmr_pkg::WD_CNT_W-1:0] windowStart;

   function automatic logic [cmr_pkg::WD_CNT_W-1:0] periodOf(input logic [2:0] r);
      int unsigned e;
      e = cmr_pkg::WD_EXP_BASE + cmr_pkg::WD_EXP_STEP * 32'(r);
      periodOf = cmr_pkg::WD_CNT_W'(e < cmr_pkg::WD_CNT_W ? (32'h1 << e) : 32'h0);
   endfunction : periodOf

   assign limit       = periodOf(rate);
   assign windowStart = limit - (limit >> 2);

   // ----------------------------------------------------------------------
   // counting
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (clear || rate == cmr_pkg::WD_RATE_OFF) begin
         count_reg   <= '0;
         expired_reg <= 1'b0;
      end else if (tickEn) begin
         if (count_reg == limit - 1'b1) begin
            count_reg   <= '0;
            expired_reg <= 1'b1;
         end else begin
            count_reg   <= count_reg + 1'b1;
            expired_reg <= 1'b0;
         end
      end else begin
         expired_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (clear) begin
         inWindow_reg <= 1'b0;
      end else begin
         inWindow_reg <= (count_reg >= windowStart);
      end
   end
endmodule : cmr_wd_counter
`default_nettype wire

// *** test/cmr_clock_mode_reset_checker.sv ***
// assertion checker for the clock mode, reset and watchdog block
`timescale 1ns/1ps
`default_nettype none
module cmr_clock_mode_reset_checker (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       pllLock,
   input wire logic       lockFlagClr,
   input wire logic       wdCfgWr,
   input wire logic       wdSvcWr,
   input wire logic [7:0] wdSvcData,
   input wire logic [4:0] postDivEff_reg,
   input wire logic       busClkFromPll_reg,
   input wire logic       oscQualified_reg,
   input wire logic       lockChangeFlag_reg,
   input wire logic       oscChangeFlag_reg,
   input wire logic       wdCfgLocked_reg,
   input wire logic [2:0] wdRate_reg,
   input wire logic       resetPinOe_reg,
   input wire logic       internalReset_reg,
   input wire logic [1:0] resetVector_reg,
   input wire logic       resetVectorValid_reg
);
   // ----------------------------------------------------------------------
   // pin drive length counter
   // ----------------------------------------------------------------------
   logic [9:0] oeCnt_reg;
   logic       oePrev_reg;
   logic       oeRose_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         oeCnt_reg  <= 10'h000;
         oePrev_reg <= 1'b1;
         oeRose_reg <= 1'b0;
      end else begin
         oeCnt_reg  <= resetPinOe_reg ? oeCnt_reg + 10'h001 : 10'h000;
         oePrev_reg <= resetPinOe_reg;
         if (resetPinOe_reg && !oePrev_reg) oeRose_reg <= 1'b1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------------
   chk_drive_len: assert property ($fell(resetPinOe_reg) && oeRose_reg |-> oeCnt_reg == 10'h200)
      else $error("reset pin drive length wrong");
   chk_release_wait: assert property ($fell(resetPinOe_reg) |-> ##256 resetVectorValid_reg)
      else $error("vector not decided after release wait");
   chk_seq_hold: assert property (resetPinOe_reg |-> internalReset_reg)
      else $error("internal reset low while pin driven");
   chk_bad_svc: assert property (!internalReset_reg && wdSvcWr && wdRate_reg != 3'h0
      && wdSvcData != cmr_pkg::WD_CODE_ARM && wdSvcData != cmr_pkg::WD_CODE_SERVE
      |=> resetPinOe_reg && internalReset_reg)
      else $error("bad service write gave no reset");
   chk_lock_flag: assert property (!internalReset_reg && pllLock != $past(pllLock)
      |=> lockChangeFlag_reg)
      else $error("lock change flag not set");
   chk_flag_clear: assert property (!internalReset_reg && lockFlagClr
      && pllLock == $past(pllLock) |=> !lockChangeFlag_reg)
      else $error("lock change flag not cleared");
   chk_osc_flag: assert property (!internalReset_reg && $changed(oscQualified_reg)
      |-> oscChangeFlag_reg)
      else $error("oscillator change flag not set");
   chk_lock_qual: assert property (!pllLock |=> !oscQualified_reg)
      else $error("qualified kept without lock");
   chk_auto_sel: assert property ($fell(oscQualified_reg) && !$past(busClkFromPll_reg)
      |-> busClkFromPll_reg)
      else $error("bus clock not returned to pll");
   chk_output_divider_field_unlk: assert property (!pllLock[*3]
      |-> postDivEff_reg == cmr_pkg::POST_DIV_UNLOCKED)
      else $error("unlocked divider not four");
   chk_cfg_lock: assert property (!internalReset_reg && wdCfgLocked_reg && wdCfgWr
      |=> $stable(wdRate_reg))
      else $error("locked rate field changed");
   cover property (resetVectorValid_reg && resetVector_reg == cmr_pkg::VEC_WATCHDOG);
   cover property (resetVectorValid_reg && resetVector_reg == cmr_pkg::VEC_CLOCK_MON);
   cover property ($fell(oscQualified_reg) && !$past(busClkFromPll_reg));
endmodule : cmr_clock_mode_reset_checker
bind cmr_clock_mode_reset cmr_clock_mode_reset_checker cmr_clock_mode_reset_checker_inst (.*);
`default_nettype wire

// *** test/cmr_pin_partner.sv ***
// reset pin circuitry and watchdog tick sources beside the block
`timescale 1ns/1ps
`default_nettype none
module cmr_pin_partner (
   input  wire logic clk,
   input  wire logic holdLow,
   input  wire logic resetPinOe_reg,
   input  wire logic resetPinOut_reg,
   output wire logic resetPinIn,
   output wire logic ircTick,
   output var  logic xtalTick
);
   // pin pulled up, low when either party drives it
   assign resetPinIn = !holdLow && (resetPinOe_reg ? resetPinOut_reg : 1'b1);
   assign ircTick    = 1'b1;
   initial xtalTick = 1'b0;
   always @(posedge clk) xtalTick <= #1 !xtalTick;
endmodule : cmr_pin_partner
`default_nettype wire

// *** test/cmr_clock_mode_reset_bench.sv ***
// self-checking bench for the clock mode, reset and watchdog block
`timescale 1ns/1ps
`default_nettype none
module cmr_clock_mode_reset_bench;
   logic clk, rst, pllCfgWr, oscEnWr, oscEnData, pllSelWr, pllSelData, lockFlagClr, oscFlagClr;
   logic pllLock, oscFilterOk, oscFilterPause, oscFail, stopMode, fullStopMode, pseudoStopEn;
   logic normalMode, wdCfgWr, wdCfgWindowEn, wdCfgClkSel, wdCfgPseudoStopEn, wdSvcWr, holdLow;
   logic ircTick, xtalTick, lowSupplyReset, illegalAddrReset, resetPinIn, pllRefFromXtal_reg;
   logic oscEnableEff_reg, busClkFromPll_reg, busClkPause_reg, vcoResetFreq_reg, wdCfgLocked_reg;
   logic oscQualified_reg, lockChangeFlag_reg, oscChangeFlag_reg, wdClkFromXtal_reg;
   logic wdWindowEn_reg, resetPinOut_reg, resetPinOe_reg, internalReset_reg, resetVectorValid_reg;
   logic [5:0] pllCfgSynDiv, synDiv_reg;
   logic [4:0] pllCfgPostDiv, postDivEff_reg;
   logic [2:0] wdCfgRate, wdRate_reg;
   logic [7:0] wdSvcData;
   logic [1:0] resetVector_reg, lastVec;
   int         nErrors = 0, nTests = 0, w;
   cmr_clock_mode_reset cmr_clock_mode_reset_inst (.*);
   cmr_pin_partner      cmr_pin_partner_inst (.*);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) if (resetVectorValid_reg === 1'b1) lastVec <= resetVector_reg;
   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task chk(input logic ok, input string msg);
      nTests++;
      if (ok !== 1'b1) begin
         nErrors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk
   task waitIdle;
      w = 0;
      while (internalReset_reg !== 1'b0 && w < 3000) begin cyc(1); w++; end
      cyc(1);
      chk(w < 3000, "reset sequence did not end");
   endtask : waitIdle
   task conclude;
      $display("mismatches %0d comparisons %0d", nErrors, nTests);
      if (nErrors == 0 && nTests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task t_boot;
      waitIdle();
      chk(synDiv_reg === 6'h1F && postDivEff_reg === 5'h03 && busClkFromPll_reg === 1'b1
         && wdClkFromXtal_reg === 1'b0 && lastVec === 2'h0, "bad defaults");
   endtask : t_boot
   task t_wd;
      wdCfgWr = 1'b1; wdCfgRate = 3'h1; cyc(1); wdCfgRate = 3'h3; cyc(1); wdCfgWr = 1'b0; cyc(1);
      chk(wdRate_reg === 3'h1 && wdCfgLocked_reg === 1'b1, "config not locked");
      cyc(3000);
      wdSvcWr = 1'b1; wdSvcData = 8'h55; cyc(1); wdSvcData = 8'hAA; cyc(1); wdSvcWr = 1'b0;
      w = 0;
      while (resetPinOe_reg !== 1'b1 && w < 5000) begin cyc(1); w++; end
      chk(w >= 4090 && w <= 4100, "timeout period wrong");
      waitIdle();
      chk(lastVec === 2'h2, "watchdog vector expected");
   endtask : t_wd
   task t_bad;
      wdCfgWr = 1'b1; wdCfgRate = 3'h1; cyc(1); wdCfgWr = 1'b0; cyc(5);
      wdSvcWr = 1'b1; wdSvcData = 8'h3C; cyc(1); wdSvcWr = 1'b0;
      chk(resetPinOe_reg === 1'b1, "bad service not reset");
      waitIdle();
      chk(lastVec === 2'h2, "watchdog vector expected");
   endtask : t_bad
   task t_win;
      wdCfgWr = 1'b1; wdCfgRate = 3'h1; wdCfgWindowEn = 1'b1; cyc(1); wdCfgWr = 1'b0; cyc(5);
      chk(wdWindowEn_reg === 1'b1, "window not enabled");
      wdSvcWr = 1'b1; wdSvcData = 8'h55; cyc(1); wdSvcWr = 1'b0;
      chk(resetPinOe_reg === 1'b1, "early service not reset");
      waitIdle();
      chk(lastVec === 2'h2, "watchdog vector expected");
   endtask : t_win
   task t_bypass;
      pllCfgWr = 1'b1; pllCfgSynDiv = 6'h1F; pllCfgPostDiv = 5'h00; cyc(1); pllCfgWr = 1'b0;
      oscEnWr = 1'b1; oscEnData = 1'b1; oscFilterOk = 1'b1; cyc(1); oscEnWr = 1'b0; cyc(8);
      chk(oscQualified_reg === 1'b1 && pllRefFromXtal_reg === 1'b1 && oscEnableEff_reg === 1'b1
         && postDivEff_reg === 5'h00, "xtal pll mode not reached");
      lockFlagClr = 1'b1; oscFlagClr = 1'b1; cyc(1); lockFlagClr = 1'b0; oscFlagClr = 1'b0;
      pllSelWr = 1'b1; pllSelData = 1'b0; cyc(1); pllSelWr = 1'b0; cyc(1);
      chk(busClkFromPll_reg === 1'b0, "bypass not selected");
      oscFilterPause = 1'b1; cyc(2);
      chk(busClkPause_reg === 1'b1, "bus clock pause missing");
      oscFilterPause = 1'b0;
      pllLock = 1'b0; cyc(3);
      chk(oscQualified_reg === 1'b0 && busClkFromPll_reg === 1'b1 && lockChangeFlag_reg === 1'b1
         && oscChangeFlag_reg === 1'b1 && postDivEff_reg === 5'h03, "lock loss");
      lockFlagClr = 1'b1; cyc(1); lockFlagClr = 1'b0; cyc(1);
      chk(lockChangeFlag_reg === 1'b0, "flag not cleared");
      pllLock = 1'b1; cyc(2);
   endtask : t_bypass
   task t_cmon;
      fullStopMode = 1'b1; cyc(1); oscFail = 1'b1; cyc(3);
      chk(resetPinOe_reg === 1'b0 && oscEnableEff_reg === 1'b0, "monitor on in full stop");
      fullStopMode = 1'b0; cyc(2);
      chk(resetPinOe_reg === 1'b1, "monitor reset missing");
      oscFail = 1'b0;
      waitIdle();
      chk(lastVec === 2'h1, "clock monitor vector expected");
   endtask : t_cmon
   task t_ext;
      holdLow = 1'b1; cyc(900);
      chk(internalReset_reg === 1'b1 && vcoResetFreq_reg === 1'b1, "not extended");
      holdLow = 1'b0;
      waitIdle();
      chk(lastVec === 2'h0, "external vector expected");
   endtask : t_ext
   initial begin
      {pllCfgWr, oscEnWr, oscEnData, pllSelWr, pllSelData, lockFlagClr, oscFlagClr} = '0;
      {oscFilterOk, oscFilterPause, oscFail, stopMode, fullStopMode, pseudoStopEn} = '0;
      {wdCfgWr, wdCfgWindowEn, wdCfgClkSel, wdCfgPseudoStopEn, wdSvcWr, holdLow} = '0;
      {lowSupplyReset, illegalAddrReset, pllCfgSynDiv, pllCfgPostDiv, wdCfgRate, wdSvcData} = '0;
      pllLock = 1'b1; normalMode = 1'b1; lastVec = 2'h3; rst = 1'b1;
      cyc(4);
      rst = 1'b0;
      t_boot(); t_wd(); t_bad(); t_win(); t_bypass(); t_cmon(); t_ext();
      conclude();
   end
   initial begin
      #(25 * 30000);
      nErrors++;
      conclude();
   end
endmodule : cmr_clock_mode_reset_bench
`default_nettype wire
